/* File: rtl/coa_pkg.sv */
package coa_pkg;
    // ****************************************
    // widths and register indices
    // ****************************************
    localparam int WORD_W = 16;
    localparam int NUM_REGS = 16;
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SP = 4'h1;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [3:0] REG_CG = 4'h3;

    // ****************************************
    // source mode codes and destination mode bit
    // ****************************************
    localparam logic [1:0] AS_DIRECT = 2'h0;
    localparam logic [1:0] AS_INDEXED = 2'h1;
    localparam logic [1:0] AS_INDIRECT = 2'h2;
    localparam logic [1:0] AS_POSTINC = 2'h3;
    localparam logic AD_INDEXED = 1'b1;

    // ****************************************
    // flags word layout
    // ****************************************
    localparam int FLG_V = 8;
    localparam int FLG_OSC = 5;
    localparam int FLG_HALT = 4;
    localparam int FLG_GIE = 3;
    localparam int FLG_N = 2;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 0;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [15:0] SR_MASK = 16'h013F;

    // ****************************************
    // generated constants and steps
    // ****************************************
    localparam logic [15:0] CONST_0 = 16'h0000;
    localparam logic [15:0] CONST_1 = 16'h0001;
    localparam logic [15:0] CONST_2 = 16'h0002;
    localparam logic [15:0] CONST_4 = 16'h0004;
    localparam logic [15:0] CONST_8 = 16'h0008;
    localparam logic [15:0] CONST_M1 = 16'hFFFF;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] ALIGN_MASK = 16'hFFFE;
    localparam logic [15:0] LOW_BYTE = 16'h00FF;
    localparam int BYTE_MSB = 7;
    localparam int WORD_MSB = 15;

    // ****************************************
    // instruction encoding
    // ****************************************
    localparam logic [3:0] OP_MOV = 4'h4;
    localparam logic [3:0] OP_ADD = 4'h5;
    localparam logic [3:0] OP_ADDC = 4'h6;
    localparam logic [3:0] OP_SUBC = 4'h7;
    localparam logic [3:0] OP_SUB = 4'h8;
    localparam logic [3:0] OP_CMP = 4'h9;
    localparam logic [3:0] OP_BIT = 4'hB;
    localparam logic [3:0] OP_BIC = 4'hC;
    localparam logic [3:0] OP_BIS = 4'hD;
    localparam logic [3:0] OP_XOR = 4'hE;
    localparam logic [3:0] OP_AND = 4'hF;
    localparam logic [5:0] SINGLE_PREFIX = 6'h04;
    localparam logic [2:0] SOP_PUSH = 3'h4;

    typedef enum logic [3:0] {
        ST_FETCH, ST_WAIT, ST_DECODE, ST_SRC, ST_SRC_EXT, ST_SRC_RD,
        ST_DST, ST_DST_EXT, ST_DST_RD, ST_EXEC
    } coa_state_t;
endpackage

/* File: rtl/coa_opnd_if.sv */
`timescale 1ns/1ps
interface coa_opnd_if;
    logic [15:0] instr;
    logic [3:0] opcode;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic [1:0] src_mode;
    logic dst_indexed;
    logic byte_op;
    logic is_dual;
    logic is_push;
    logic src_is_const;
    logic src_ext;
    logic src_zero_base;
    logic [15:0] const_val;
    logic [15:0] post_step;
    modport core (output instr, input opcode, src_reg, dst_reg, src_mode, dst_indexed, byte_op, is_dual,
        is_push, src_is_const, src_ext, src_zero_base, const_val, post_step);
    modport dec (input instr, output opcode, src_reg, dst_reg, src_mode, dst_indexed, byte_op, is_dual,
        is_push, src_is_const, src_ext, src_zero_base, const_val, post_step);
endinterface

/* File: rtl/coa_operand_decode.sv */
`timescale 1ns/1ps
module coa_operand_decode (
    coa_opnd_if.dec opnd
);
    // ****************************************
    // field split
    // ****************************************
    wire [15:0] ir = opnd.instr;
    wire sing = (ir[15:10] == coa_pkg::SINGLE_PREFIX);
    wire src_sr = (opnd.src_reg == coa_pkg::REG_SR);
    wire src_cg = (opnd.src_reg == coa_pkg::REG_CG);
    wire src_sp_pc = (opnd.src_reg == coa_pkg::REG_SP) || (opnd.src_reg == coa_pkg::REG_PC);

    // dual operand words carry the opcode in the top nibble; single ones keep src in the low field
    assign opnd.opcode = ir[15:12];
    assign opnd.is_dual = (ir[15:12] >= coa_pkg::OP_MOV);
    assign opnd.is_push = sing && (ir[9:7] == coa_pkg::SOP_PUSH);
    assign opnd.src_reg = opnd.is_dual ? ir[11:8] : ir[3:0];
    assign opnd.dst_reg = ir[3:0];
    assign opnd.src_mode = ir[5:4];
    assign opnd.dst_indexed = opnd.is_dual && (ir[7] == coa_pkg::AD_INDEXED);
    assign opnd.byte_op = ir[6];

    // flags word direct stays a register, indexed uses a zero base, its indirect and autoincrement modes and every const_reg_b mode are constants
    assign opnd.src_is_const = src_cg || (src_sr && opnd.src_mode[1]);
    assign opnd.src_zero_base = src_sr && (opnd.src_mode == coa_pkg::AS_INDEXED);
    assign opnd.src_ext = (opnd.src_mode == coa_pkg::AS_INDEXED) && !src_cg;

    // stack and instruction pointers always step by a word to stay even
    assign opnd.post_step = (src_sp_pc || !opnd.byte_op) ? coa_pkg::WORD_STEP : coa_pkg::BYTE_STEP;

    // constant generator table
    always_comb begin
        opnd.const_val = coa_pkg::CONST_0;
        if (src_cg) begin
            case (opnd.src_mode)
                coa_pkg::AS_DIRECT: opnd.const_val = coa_pkg::CONST_0;
                coa_pkg::AS_INDEXED: opnd.const_val = coa_pkg::CONST_1;
                coa_pkg::AS_INDIRECT: opnd.const_val = coa_pkg::CONST_2;
                default: opnd.const_val = coa_pkg::CONST_M1;
            endcase
        end else if (opnd.src_mode == coa_pkg::AS_INDIRECT) begin
            opnd.const_val = coa_pkg::CONST_4;
        end else begin
            opnd.const_val = coa_pkg::CONST_8;
        end
    end
endmodule

/* File: rtl/coa_core.sv */
`timescale 1ns/1ps
module coa_core (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [15:0] i_ibus_rdata,
    input wire logic [15:0] i_dbus_rdata,
    output logic o_ibus_req,
    output logic [15:0] o_ibus_addr,
    output logic o_dbus_req,
    output logic o_dbus_we,
    output logic o_dbus_byte,
    output logic [15:0] o_dbus_addr,
    output logic [15:0] o_dbus_wdata,
    output logic [15:0] o_status_flags,
    output logic o_irq_enable,
    output logic o_core_halt,
    output logic o_osc_halt
);
    // ****************************************
    // helpers
    // ****************************************
    // address sums simply wrap; the high carry is dropped on purpose
    function automatic logic [15:0] ea_sum(input logic [15:0] base, input logic [15:0] offs);
        logic [16:0] s;
        s = {1'b0, base} + {1'b0, offs};
        return s[15:0];
    endfunction

    // picks the addressed byte lane for byte reads
    function automatic logic [15:0] lane(input logic [15:0] w, input logic odd, input logic byt);
        logic [15:0] r;
        r = w;
        if (byt) begin
            r = odd ? {8'h00, w[15:8]} : (w & coa_pkg::LOW_BYTE);
        end
        return r;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [15:0] regs [coa_pkg::NUM_REGS];
    coa_pkg::coa_state_t state;
    coa_pkg::coa_state_t wait_ret;
    logic [15:0] src_val;
    logic [15:0] dst_val;
    logic [15:0] ea;
    logic from_ibus;

    coa_opnd_if opnd ();
    logic [15:0] instr;
    assign opnd.instr = instr;

    coa_operand_decode u_dec (
        .opnd(opnd)
    );

    // ****************************************
    // operand selection
    // ****************************************
    wire [15:0] pc = regs[coa_pkg::REG_PC];
    wire [15:0] sp = regs[coa_pkg::REG_SP];
    wire [15:0] sr = regs[coa_pkg::REG_SR];
    wire byt = opnd.byte_op;
    wire [15:0] src_reg_val = regs[opnd.src_reg];
    wire [15:0] dst_reg_val = regs[opnd.dst_reg];
    wire src_is_pc = (opnd.src_reg == coa_pkg::REG_PC);
    wire [15:0] src_base = opnd.src_zero_base ? coa_pkg::CONST_0 : src_reg_val;
    wire [15:0] dst_base = (opnd.dst_reg == coa_pkg::REG_SR) ? coa_pkg::CONST_0 : dst_reg_val;
    wire [15:0] rd_word = from_ibus ? i_ibus_rdata : i_dbus_rdata;
    wire [15:0] rd_val = lane(rd_word, ea[0], byt);
    wire [15:0] push_addr = sp - coa_pkg::WORD_STEP;

    // ****************************************
    // arithmetic and flags
    // ****************************************
    wire [3:0] op = opnd.opcode;
    wire is_sub = (op == coa_pkg::OP_SUB) || (op == coa_pkg::OP_SUBC) || (op == coa_pkg::OP_CMP);
    wire use_cin = (op == coa_pkg::OP_ADDC) || (op == coa_pkg::OP_SUBC);
    wire is_arith = (op == coa_pkg::OP_ADD) || use_cin || is_sub;
    wire [15:0] addend = is_sub ? ~src_val : src_val;
    wire cin = use_cin ? sr[coa_pkg::FLG_C] : is_sub;
    wire [16:0] sum_w = {1'b0, dst_val} + {1'b0, addend} + {16'h0000, cin};
    wire [8:0] sum_b = {1'b0, dst_val[7:0]} + {1'b0, addend[7:0]} + {8'h00, cin};
    logic [15:0] alu;

    // result per opcode; unknown encodings keep the destination
    always_comb begin
        case (op)
            coa_pkg::OP_MOV: alu = src_val;
            coa_pkg::OP_BIC: alu = dst_val & ~src_val;
            coa_pkg::OP_BIS: alu = dst_val | src_val;
            coa_pkg::OP_XOR: alu = dst_val ^ src_val;
            coa_pkg::OP_AND: alu = dst_val & src_val;
            coa_pkg::OP_BIT: alu = dst_val & src_val;
            default: alu = is_arith ? sum_w[15:0] : dst_val;
        endcase
    end

    wire [15:0] res = byt ? (alu & coa_pkg::LOW_BYTE) : alu;
    wire res_msb = byt ? res[coa_pkg::BYTE_MSB] : res[coa_pkg::WORD_MSB];
    wire a_msb = byt ? dst_val[coa_pkg::BYTE_MSB] : dst_val[coa_pkg::WORD_MSB];
    wire b_msb = byt ? addend[coa_pkg::BYTE_MSB] : addend[coa_pkg::WORD_MSB];
    wire s_msb = byt ? src_val[coa_pkg::BYTE_MSB] : src_val[coa_pkg::WORD_MSB];
    wire res_zero = (res == coa_pkg::CONST_0);
    wire carry = byt ? sum_b[8] : sum_w[16];
    wire ovf = is_arith ? ((a_msb == b_msb) && (res_msb != a_msb)) :
        ((op == coa_pkg::OP_XOR) && a_msb && s_msb);
    wire sets_flags = is_arith || (op == coa_pkg::OP_XOR) || (op == coa_pkg::OP_AND) || (op == coa_pkg::OP_BIT);
    wire writes_dst = (op != coa_pkg::OP_CMP) && (op != coa_pkg::OP_BIT);
    logic [15:0] next_sr;

    // logic ops report carry as "result not zero"
    always_comb begin
        next_sr = sr;
        next_sr[coa_pkg::FLG_V] = ovf;
        next_sr[coa_pkg::FLG_N] = res_msb;
        next_sr[coa_pkg::FLG_Z] = res_zero;
        next_sr[coa_pkg::FLG_C] = is_arith ? carry : !res_zero;
    end

    // ****************************************
    // sequencer
    // ****************************************
    // every memory access: request flop high in ST_WAIT; for a read, data is taken in the state after
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < coa_pkg::NUM_REGS; i++) begin
                regs[i] <= coa_pkg::CONST_0;
            end
            regs[coa_pkg::REG_SR] <= coa_pkg::SR_RESET;
            state <= coa_pkg::ST_FETCH;
            wait_ret <= coa_pkg::ST_FETCH;
            instr <= coa_pkg::CONST_0;
            src_val <= coa_pkg::CONST_0;
            dst_val <= coa_pkg::CONST_0;
            ea <= coa_pkg::CONST_0;
            from_ibus <= 1'b0;
            o_ibus_req <= 1'b0;
            o_ibus_addr <= coa_pkg::CONST_0;
            o_dbus_req <= 1'b0;
            o_dbus_we <= 1'b0;
            o_dbus_byte <= 1'b0;
            o_dbus_addr <= coa_pkg::CONST_0;
            o_dbus_wdata <= coa_pkg::CONST_0;
        end else begin
            o_ibus_req <= 1'b0;
            o_dbus_req <= 1'b0;
            o_dbus_we <= 1'b0;
            case (state)
                coa_pkg::ST_FETCH: begin
                    o_ibus_req <= 1'b1;
                    o_ibus_addr <= pc & coa_pkg::ALIGN_MASK;
                    wait_ret <= coa_pkg::ST_DECODE;
                    state <= coa_pkg::ST_WAIT;
                end
                coa_pkg::ST_WAIT: begin
                    state <= wait_ret;
                end
                coa_pkg::ST_DECODE: begin
                    instr <= i_ibus_rdata;
                    regs[coa_pkg::REG_PC] <= pc + coa_pkg::WORD_STEP;
                    state <= coa_pkg::ST_SRC;
                end
                coa_pkg::ST_SRC: begin
                    if (!opnd.is_dual && !opnd.is_push) begin
                        state <= coa_pkg::ST_FETCH;
                    end else if (opnd.src_is_const) begin
                        src_val <= lane(opnd.const_val, 1'b0, byt);
                        state <= coa_pkg::ST_DST;
                    end else if (opnd.src_mode == coa_pkg::AS_DIRECT) begin
                        src_val <= lane(src_reg_val, 1'b0, byt);
                        state <= coa_pkg::ST_DST;
                    end else if (opnd.src_ext) begin
                        o_ibus_req <= 1'b1;
                        o_ibus_addr <= pc;
                        wait_ret <= coa_pkg::ST_SRC_EXT;
                        state <= coa_pkg::ST_WAIT;
                    end else begin
                        // an indirect through instr_pointer reads the instruction stream
                        from_ibus <= src_is_pc;
                        ea <= src_reg_val;
                        // only the bus that is asked moves its address, the idle one keeps its last value
                        if (src_is_pc) begin
                            o_ibus_req <= 1'b1;
                            o_ibus_addr <= src_reg_val;
                        end else begin
                            o_dbus_req <= 1'b1;
                            o_dbus_addr <= src_reg_val;
                            o_dbus_byte <= byt;
                        end
                        wait_ret <= coa_pkg::ST_SRC_RD;
                        state <= coa_pkg::ST_WAIT;
                    end
                end
                coa_pkg::ST_SRC_EXT: begin
                    regs[coa_pkg::REG_PC] <= pc + coa_pkg::WORD_STEP;
                    from_ibus <= 1'b0;
                    ea <= ea_sum(src_base, i_ibus_rdata);
                    o_dbus_req <= 1'b1;
                    o_dbus_addr <= ea_sum(src_base, i_ibus_rdata);
                    o_dbus_byte <= byt;
                    wait_ret <= coa_pkg::ST_SRC_RD;
                    state <= coa_pkg::ST_WAIT;
                end
                coa_pkg::ST_SRC_RD: begin
                    src_val <= rd_val;
                    if (opnd.src_mode == coa_pkg::AS_POSTINC) begin
                        regs[opnd.src_reg] <= src_reg_val + opnd.post_step;
                    end
                    state <= coa_pkg::ST_DST;
                end
                coa_pkg::ST_DST: begin
                    if (opnd.is_push) begin
                        regs[coa_pkg::REG_SP] <= push_addr;
                        o_dbus_req <= 1'b1;
                        o_dbus_we <= 1'b1;
                        o_dbus_byte <= byt;
                        o_dbus_addr <= push_addr;
                        o_dbus_wdata <= byt ? {src_val[7:0], src_val[7:0]} : src_val;
                        wait_ret <= coa_pkg::ST_FETCH;
                        state <= coa_pkg::ST_WAIT;
                    end else if (opnd.dst_indexed) begin
                        o_ibus_req <= 1'b1;
                        o_ibus_addr <= pc;
                        wait_ret <= coa_pkg::ST_DST_EXT;
                        state <= coa_pkg::ST_WAIT;
                    end else begin
                        dst_val <= lane(dst_reg_val, 1'b0, byt);
                        state <= coa_pkg::ST_EXEC;
                    end
                end
                coa_pkg::ST_DST_EXT: begin
                    regs[coa_pkg::REG_PC] <= pc + coa_pkg::WORD_STEP;
                    from_ibus <= 1'b0;
                    ea <= ea_sum(dst_base, i_ibus_rdata);
                    if (op == coa_pkg::OP_MOV) begin
                        state <= coa_pkg::ST_EXEC;
                    end else begin
                        o_dbus_req <= 1'b1;
                        o_dbus_addr <= ea_sum(dst_base, i_ibus_rdata);
                        o_dbus_byte <= byt;
                        wait_ret <= coa_pkg::ST_DST_RD;
                        state <= coa_pkg::ST_WAIT;
                    end
                end
                coa_pkg::ST_DST_RD: begin
                    dst_val <= rd_val;
                    state <= coa_pkg::ST_EXEC;
                end
                default: begin
                    // flags first so that a write of the flags word as destination wins
                    state <= coa_pkg::ST_FETCH;
                    if (sets_flags) begin
                        regs[coa_pkg::REG_SR] <= next_sr & coa_pkg::SR_MASK;
                    end
                    if (writes_dst && opnd.dst_indexed) begin
                        o_dbus_req <= 1'b1;
                        o_dbus_we <= 1'b1;
                        o_dbus_byte <= byt;
                        o_dbus_addr <= ea;
                        o_dbus_wdata <= byt ? {res[7:0], res[7:0]} : res;
                        wait_ret <= coa_pkg::ST_FETCH;
                        state <= coa_pkg::ST_WAIT;
                    end else if (writes_dst) begin
                        if (opnd.dst_reg == coa_pkg::REG_SR) begin
                            regs[coa_pkg::REG_SR] <= res & coa_pkg::SR_MASK;
                        end else if (opnd.dst_reg == coa_pkg::REG_PC || opnd.dst_reg == coa_pkg::REG_SP) begin
                            regs[opnd.dst_reg] <= res & coa_pkg::ALIGN_MASK;
                        end else if (opnd.dst_reg != coa_pkg::REG_CG) begin
                            regs[opnd.dst_reg] <= res;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************
    // flag outputs
    // ****************************************
    // mask output lags the flags word by one cycle, so one more instruction may be interrupted
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_irq_enable <= 1'b0;
            o_status_flags <= coa_pkg::SR_RESET;
        end else begin
            o_irq_enable <= sr[coa_pkg::FLG_GIE];
            o_status_flags <= sr;
        end
    end

    assign o_core_halt = o_status_flags[coa_pkg::FLG_HALT];
    assign o_osc_halt = o_status_flags[coa_pkg::FLG_OSC];
endmodule

/* File: verification/coa_core_chk.sv */
`timescale 1ns/1ps
module coa_core_chk (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic o_ibus_req,
    input wire logic [15:0] o_ibus_addr,
    input wire logic o_dbus_req,
    input wire logic [15:0] o_dbus_addr,
    input wire logic [15:0] o_status_flags,
    input wire logic o_irq_enable,
    input wire logic o_core_halt,
    input wire logic o_osc_halt
);
    // ****************************************
    // port relations of the core
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_fetch_even: assert property (o_ibus_req |-> !o_ibus_addr[0])
        else $error("instruction fetch from odd address");
    a_first_fetch: assert property ($fell(i_sys_rst) |-> o_status_flags == 16'h0000 ##1
        (o_ibus_req && o_ibus_addr == 16'h0000)) else $error("first fetch not at address zero");
    // memory cannot stall, so requests must leave a gap for the answer cycle
    a_one_bus: assert property ((o_ibus_req || o_dbus_req) |-> !(o_ibus_req && o_dbus_req)
        ##1 !(o_ibus_req || o_dbus_req)) else $error("bus requests overlap or back to back");
    a_iaddr_hold: assert property (!o_ibus_req |-> $stable(o_ibus_addr))
        else $error("fetch address moved without request");
    a_daddr_hold: assert property (!o_dbus_req |-> $stable(o_dbus_addr))
        else $error("data address moved without request");
    a_halt_bit: assert property (o_core_halt == o_status_flags[4])
        else $error("halt output differs from flag bit");
    a_osc_bit: assert property (o_osc_halt == o_status_flags[5])
        else $error("oscillator output differs from flag bit");
    a_spare_zero: assert property ((o_status_flags & 16'hFEC0) == 16'h0000)
        else $error("unused flag bits set");
    a_irq_mirror: assert property (o_irq_enable == o_status_flags[3])
        else $error("interrupt enable differs from flag bit");
endmodule

/* File: verification/coa_mem_model.sv */
`timescale 1ns/1ps
module coa_mem_model (
    input wire logic i_ref_clk,
    input wire logic i_ibus_req,
    input wire logic [15:0] i_ibus_addr,
    input wire logic i_dbus_req,
    input wire logic i_dbus_we,
    input wire logic i_dbus_byte,
    input wire logic [15:0] i_dbus_addr,
    input wire logic [15:0] i_dbus_wdata,
    output logic [15:0] o_ibus_rdata,
    output logic [15:0] o_dbus_rdata
);
    logic [15:0] prog [0:63];
    logic [15:0] ram [0:32767];
    logic [15:0] wr_addr [0:31];
    logic [15:0] wr_data [0:31];
    logic [15:0] irq_data = 16'h0000;
    logic [15:0] drd_data = 16'h0000;
    int wr_cnt = 0;
    assign o_ibus_rdata = irq_data;
    assign o_dbus_rdata = drd_data;
    // ****************************************
    // zero wait memory
    // ****************************************
    // answer only in the cycle after a request; idle lines toggle so stale data is never mistaken
    always @(posedge i_ref_clk) begin
        irq_data <= i_ibus_req ? (i_ibus_addr[15:7] == 9'h000 ? prog[i_ibus_addr[6:1]] : 16'h0000) : ~irq_data;
        drd_data <= (i_dbus_req && !i_dbus_we) ? ram[i_dbus_addr[15:1]] : ~drd_data;
        if (i_dbus_req && i_dbus_we) begin
            if (!i_dbus_byte) ram[i_dbus_addr[15:1]] <= i_dbus_wdata;
            else if (i_dbus_addr[0]) ram[i_dbus_addr[15:1]][15:8] <= i_dbus_wdata[15:8];
            else ram[i_dbus_addr[15:1]][7:0] <= i_dbus_wdata[7:0];
            wr_addr[wr_cnt[4:0]] <= i_dbus_addr;
            wr_data[wr_cnt[4:0]] <= i_dbus_wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule

/* File: verification/test_cpu_operand_addressing.sv */
`timescale 1ns/1ps
module test_cpu_operand_addressing;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [15:0] ibus_rdata, dbus_rdata, ibus_addr, dbus_addr, dbus_wdata, flags;
    logic ibus_req, dbus_req, dbus_we, dbus_byte, irq_en, halt, osc;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    // constants via both generator registers, flag pushes, byte ops, pop, immediate, wrapped index,
    // then interrupt enable and both halt bits set in the flags word and pushed
    localparam logic [15:0] PROG [0:32] = '{16'h4304, 16'h1204, 16'h4314, 16'h1204, 16'h4324, 16'h1204,
        16'h4334, 16'h1204, 16'h4224, 16'h1204, 16'h4234, 16'h1204, 16'h4335, 16'h5315, 16'h1202,
        16'h4375, 16'h1205, 16'h5345, 16'h1202, 16'h4036, 16'h7FFF, 16'h5316, 16'h1202, 16'h4137,
        16'h1207, 16'h4177, 16'h1207, 16'h4339, 16'h4589, 16'h0005, 16'hD032, 16'h0038, 16'h1202};
    localparam logic [15:0] EXP_A [0:13] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4,
        16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEC, 16'hFFEC, 16'h0004, 16'hFFEA};
    localparam logic [15:0] EXP_D [0:13] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF, 16'h0004, 16'h0008,
        16'h0003, 16'h00FF, 16'h0004, 16'h0104, 16'h0104, 16'h0004, 16'h00FF, 16'h013C};
    initial begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    coa_core dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ibus_rdata(ibus_rdata),
        .i_dbus_rdata(dbus_rdata), .o_ibus_req(ibus_req), .o_ibus_addr(ibus_addr), .o_dbus_req(dbus_req),
        .o_dbus_we(dbus_we), .o_dbus_byte(dbus_byte), .o_dbus_addr(dbus_addr), .o_dbus_wdata(dbus_wdata),
        .o_status_flags(flags), .o_irq_enable(irq_en), .o_core_halt(halt), .o_osc_halt(osc));
    coa_mem_model mem (.i_ref_clk(i_ref_clk), .i_ibus_req(ibus_req), .i_ibus_addr(ibus_addr),
        .i_dbus_req(dbus_req), .i_dbus_we(dbus_we), .i_dbus_byte(dbus_byte), .i_dbus_addr(dbus_addr),
        .i_dbus_wdata(dbus_wdata), .o_ibus_rdata(ibus_rdata), .o_dbus_rdata(dbus_rdata));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // watchdog and main sequence
    // ****************************************
    // the program needs under two hundred cycles; a hang counts as a mismatch
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        for (int i = 0; i < 64; i++) mem.prog[i] = (i < 33) ? PROG[i] : 16'h0000;
        repeat (4) @(posedge i_ref_clk);
        #1 chk(flags, 16'h0000);
        @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        while (mem.wr_cnt < 14) @(posedge i_ref_clk);
        for (int k = 0; k < 14; k++) chk(mem.wr_addr[k], EXP_A[k]);
        for (int k = 0; k < 14; k++) chk(mem.wr_data[k], EXP_D[k]);
        chk(flags, 16'h013C);
        chk({15'h0000, irq_en}, 16'h0001);
        chk({14'h0000, osc, halt}, 16'h0003);
        tally_and_finish();
    end
endmodule
bind coa_core coa_core_chk u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .o_ibus_req(o_ibus_req),
    .o_ibus_addr(o_ibus_addr), .o_dbus_req(o_dbus_req), .o_dbus_addr(o_dbus_addr),
    .o_status_flags(o_status_flags), .o_irq_enable(o_irq_enable), .o_core_halt(o_core_halt),
    .o_osc_halt(o_osc_halt));
